//--- rtl/dpram_port_ctrl.sv
module dpram_port_ctrl
  import dpram_ctrl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [dpram_ctrl_pkg::ADDR_W-1:0] mem_addr,
  output logic port_select_n,
  output logic semaphore_select_n,
  output logic rw_n,
  output logic oe_n,
  output logic [3:0] byte_lane_selects_n,
  output logic bus_match_select,
  output logic bus_size_select,
  output logic [dpram_ctrl_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic [dpram_ctrl_pkg::DATA_W-1:0] dq_in,
  input wire logic busy_n,
  input wire logic mailbox_irq_n
);
  import dpram_ctrl_pkg::*;

  typedef enum logic [2:0] {IDLE, SETUP, STROBE, RECOVER, SEM_GAP, SAMPLE} state_type;

  state_type state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [31:0] cmd_q, cmd_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic done_q, done_d, busy_seen_q, busy_seen_d;
  logic [1:0] busy_sync_q, irq_sync_q;
  logic ap_wr_q, ap_rd_q;
  logic [31:0] ap_addr_q;
  logic ap_wr_d, ap_rd_d;
  logic [31:0] ap_addr_d;
  logic [DATA_W-1:0] dq_meta_q, dq_sync_q;

  function automatic logic [CNT_W-1:0] load_cnt(input int n);
    return CNT_W'(n);
  endfunction : load_cnt

  // read data passes two flops; only safe while the strobe lasts at least three edges
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dq_meta_q <= '0;
      dq_sync_q <= '0;
    end else begin
      dq_meta_q <= dq_in;
      dq_sync_q <= dq_meta_q;
    end
  end

  // pins cross from an asynchronous device
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      busy_sync_q <= 2'h3;
      irq_sync_q <= 2'h3;
    end else begin
      busy_sync_q <= {busy_sync_q[0], busy_n};
      irq_sync_q <= {irq_sync_q[0], mailbox_irq_n};
    end
  end

  wire busy_s = ~busy_sync_q[1];
  wire irq_s = ~irq_sync_q[1];
  wire is_sem = cmd_q[CMD_SEM];
  wire is_wr = cmd_q[CMD_WRITE];
  wire ctrl_idle = (state_q == IDLE);

  always_comb begin
    ap_wr_d = 1'b0;
    ap_rd_d = 1'b0;
    ap_addr_d = ap_addr_q;
    if (hready && hsel && htrans[1]) begin
      ap_wr_d = hwrite;
      ap_rd_d = ~hwrite;
      ap_addr_d = haddr;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ap_wr_q <= 1'b0;
      ap_rd_q <= 1'b0;
      ap_addr_q <= 32'h0000_0000;
    end else begin
      ap_wr_q <= ap_wr_d;
      ap_rd_q <= ap_rd_d;
      ap_addr_q <= ap_addr_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_comb begin
    hrdata = 32'h0000_0000;
    if (ap_rd_q) begin
      unique case (ap_addr_q)
        REG_CMD: hrdata = cmd_q;
        REG_ADDR: hrdata = 32'(addr_q);
        REG_WDATA: hrdata = wdata_q[31:0];
        REG_RDATA: hrdata = rdata_q[31:0];
        REG_RDATA_HI: hrdata = 32'(rdata_q[DATA_W-1:32]);
        REG_STATUS: hrdata = {28'h000_0000, irq_s, busy_s, busy_seen_q, done_q | ctrl_idle};
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    cmd_d = cmd_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    done_d = done_q;
    busy_seen_d = busy_seen_q;
    cmd_d[CMD_GO] = 1'b0;
    // registers only change while the pins are quiet
    if (ap_wr_q && ctrl_idle) begin
      unique case (ap_addr_q)
        REG_CMD: cmd_d = hwdata;
        REG_ADDR: addr_d = hwdata[ADDR_W-1:0];
        REG_WDATA: wdata_d = DATA_W'(hwdata);
        default: ;
      endcase
    end
    unique case (state_q)
      IDLE: if (cmd_q[CMD_GO]) begin
        state_d = SETUP;
        cnt_d = load_cnt(SETUP_CYC);
        done_d = 1'b0;
        busy_seen_d = 1'b0;
      end
      SETUP: begin
        // slave writes wait for settled busy
        if (cnt_q != '0) cnt_d = cnt_q - 1'b1;
        else if (!busy_s) begin
          state_d = STROBE;
          cnt_d = load_cnt(PULSE_CYC + BUSY_CYC);
        end else busy_seen_d = 1'b1;
      end
      STROBE: begin
        if (busy_s) busy_seen_d = 1'b1;
        if (cnt_q != '0) cnt_d = cnt_q - 1'b1;
        else begin
          if (!is_wr) rdata_d = dq_sync_q;
          state_d = RECOVER;
          cnt_d = load_cnt(GAP_CYC);
        end
      end
      RECOVER: begin
        // selects outlast the strobe so address and select hold past its end
        if (cnt_q != '0) cnt_d = cnt_q - 1'b1;
        else begin
          state_d = (is_sem && is_wr) ? SEM_GAP : SAMPLE;
        end
      end
      SEM_GAP: begin
        // select off a whole cycle here, longer than the flag update pulse
        cmd_d[CMD_WRITE] = 1'b0;
        state_d = SETUP;
        cnt_d = load_cnt(SETUP_CYC);
      end
      SAMPLE: begin
        done_d = 1'b1;
        state_d = IDLE;
      end
      default: state_d = IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= IDLE;
      cnt_q <= '0;
      cmd_q <= 32'h0000_0000;
      addr_q <= '0;
      wdata_q <= '0;
      rdata_q <= '0;
      done_q <= 1'b0;
      busy_seen_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      cmd_q <= cmd_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      done_q <= done_d;
      busy_seen_q <= busy_seen_d;
    end
  end

  wire active = (state_q == SETUP) || (state_q == STROBE) || (state_q == RECOVER);
  wire strobing = (state_q == STROBE);

  // pins come from flip-flops via state; address held stable
  always_comb begin
    mem_addr = addr_q;
    port_select_n = 1'b1;
    semaphore_select_n = 1'b1;
    byte_lane_selects_n = 4'h0;
    bus_match_select = 1'b0;
    bus_size_select = 1'b0;
    if (is_sem) begin
      // only the three index lines matter to the latch
      mem_addr = {{(ADDR_W-SEM_IDX_W){1'b0}}, addr_q[SEM_IDX_W-1:0]};
      semaphore_select_n = ~active;
      byte_lane_selects_n = 4'hF;
      if (cmd_q[CMD_RIGHT_ACTIVE]) begin
        port_select_n = ~active;
        bus_size_select = 1'b1;
      end
    end else begin
      port_select_n = ~active;
    end
  end

  assign rw_n = ~(strobing && is_wr);
  assign oe_n = ~(strobing && !is_wr);
  // latch writes put the request on bit zero only
  assign dq_out = is_sem ? {{(DATA_W-1){1'b0}}, wdata_q[0]} : wdata_q;
  assign dq_oe = strobing && is_wr;

  a_sem_no_ce: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!semaphore_select_n && !cmd_q[CMD_RIGHT_ACTIVE]) |-> port_select_n)
    else $error("port select active during latch access");
  a_oe_rw_excl: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !(!rw_n && !oe_n)) else $error("read and write strobes together");

  sequence s_latch_wr_end;
    is_sem && is_wr && (state_q == RECOVER) && (cnt_q == '0);
  endsequence

  sequence s_deselect;
    semaphore_select_n && oe_n && rw_n;
  endsequence

  sequence s_read_back;
    !semaphore_select_n && rw_n && !is_wr;
  endsequence

  a_gap_after_wr: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_latch_wr_end |=> s_deselect ##1 s_read_back)
    else $error("latch not deselected before read back");

  a_sel_over_wr: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ($rose(rw_n) && is_sem) |-> !semaphore_select_n)
    else $error("latch select dropped with the write strobe");

  a_addr_steady: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !rw_n |=> $stable(mem_addr))
    else $error("address moved during write");

  a_lanes_plain: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !is_sem |-> (byte_lane_selects_n == 4'h0))
    else $error("byte lanes off during array access");

  a_wr_drives: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !rw_n |-> dq_oe)
    else $error("write strobe without data drive");

  a_idle_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ctrl_idle |-> (port_select_n && semaphore_select_n && rw_n && oe_n))
    else $error("pins active while idle");

  a_right_mode: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!semaphore_select_n && cmd_q[CMD_RIGHT_ACTIVE]) |-> (bus_size_select && !bus_match_select && !port_select_n))
    else $error("right port latch mode pins wrong");

  a_go_starts: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ctrl_idle && cmd_q[CMD_GO]) |=> (state_q == SETUP))
    else $error("go did not start a cycle");

  a_busy_no_strobe: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_q == SETUP && busy_s) |=> !strobing)
    else $error("strobe started under busy");

  a_idx_only: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !semaphore_select_n |-> (mem_addr[ADDR_W-1:3] == '0))
    else $error("high address lines driven during latch access");
  a_bit0_only: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (dq_oe && is_sem) |-> (dq_out[DATA_W-1:1] == '0))
    else $error("latch write drives upper data");
  a_busy_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_q == SETUP && cnt_q == '0 && busy_s) |=> rw_n)
    else $error("write started under busy");
endmodule : dpram_port_ctrl

//--- rtl/dpram_ctrl_pkg.sv
package dpram_ctrl_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 36;
  localparam logic [31:0] REG_CMD = 32'h0000_0000;
  localparam logic [31:0] REG_ADDR = 32'h0000_0004;
  localparam logic [31:0] REG_WDATA = 32'h0000_0008;
  localparam logic [31:0] REG_RDATA = 32'h0000_000C;
  localparam logic [31:0] REG_STATUS = 32'h0000_0010;
  localparam logic [31:0] REG_RDATA_HI = 32'h0000_0014;
  localparam int CMD_GO = 0;
  localparam int CMD_WRITE = 1;
  localparam int CMD_SEM = 2;
  localparam int CMD_RIGHT_ACTIVE = 3;
  localparam int CLK_NS = 40;
  localparam int SETUP_NS = 20;
  localparam int PULSE_NS = 20;
  localparam int SOP_NS = 10;
  localparam int SWRD_NS = 5;
  localparam int DOE_NS = 20;
  localparam int BUSY_NS = 20;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_CYC = (SOP_NS + SWRD_NS + DOE_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUSY_CYC = (BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 4;
  localparam int SEM_IDX_W = 3;
endpackage : dpram_ctrl_pkg

//--- testbench/dpram_dev_model.sv
module dpram_dev_model
  import dpram_ctrl_pkg::*;
(
  input wire logic [dpram_ctrl_pkg::ADDR_W-1:0] mem_addr,
  input wire logic port_select_n,
  input wire logic semaphore_select_n,
  input wire logic rw_n,
  input wire logic oe_n,
  input wire logic [3:0] byte_lane_selects_n,
  input wire logic bus_match_select,
  input wire logic bus_size_select,
  input wire logic [dpram_ctrl_pkg::DATA_W-1:0] dq_out,
  output logic [dpram_ctrl_pkg::DATA_W-1:0] dq_in,
  output logic busy_n,
  output logic mailbox_irq_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] own [8];
  logic want [8][3];
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic peer_irq = 1'b0;
  logic flip = 1'b0;
  logic sem_sel;
  initial begin
    foreach (own[i]) own[i] = 2'h0;
    foreach (want[i, j]) want[i][j] = 1'b0;
    mailbox_irq_n = 1'b1;
  end
  // no peer modelled; the bench pulls busy low to act as the master
  logic busy_drv = 1'b1;
  assign busy_n = busy_drv;
  always #20 flip = ~flip;
  assign sem_sel = !semaphore_select_n && (port_select_n || &byte_lane_selects_n ||
    (!bus_match_select && bus_size_select));
  // owner code 1 is this port, 2 is the peer
  task automatic sem_wr(input int i, input int p, input logic v);
    if (!v) begin
      if (own[i] == 2'h0) own[i] = 2'(p);
      else if (own[i] != 2'(p)) want[i][p] = 1'b1;
    end else begin
      want[i][p] = 1'b0;
      if (own[i] == 2'(p)) begin
        own[i] = want[i][3-p] ? 2'(3 - p) : 2'h0;
        want[i][3-p] = 1'b0;
      end
    end
  endtask : sem_wr
  task automatic post(input logic [DATA_W-1:0] m);
    mem[15'h7ffe] = m;
    mailbox_irq_n = 1'b0;
  endtask : post
  always @(posedge rw_n) begin
    if (sem_sel) sem_wr(int'(mem_addr[2:0]), 1, dq_out[0]);
    else if (!port_select_n) begin
      mem[mem_addr] = dq_out;
      if (mem_addr == 15'h7fff && busy_n) peer_irq = 1'b1;
    end
  end
  always @(posedge oe_n) begin
    if (!port_select_n && semaphore_select_n && mem_addr == 15'h7ffe && busy_n) begin
      mailbox_irq_n = 1'b1;
    end
  end
  // released bus toggles so a stale sample never looks valid
  always @* dq_in = oe_n ? {DATA_W{flip}} : sem_sel ?
    {{(DATA_W-1){1'b0}}, own[mem_addr[2:0]] != 2'h1} : mem[mem_addr];
endmodule : dpram_dev_model

//--- testbench/tb_dual_port_arbiter_mailbox_semaphore.sv
module tb_dual_port_arbiter_mailbox_semaphore;
  import dpram_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, sys_rst, hwrite, hreadyout, port_select_n, semaphore_select_n, rw_n, oe_n;
  logic bus_match_select, bus_size_select, busy_n, mailbox_irq_n;
  logic [1:0] htrans;
  logic [3:0] byte_lane_selects_n;
  logic [31:0] haddr, hwdata, hrdata, got_d, r;
  logic [ADDR_W-1:0] mem_addr;
  logic [DATA_W-1:0] dq_out, dq_in;
  logic [63:0] exp_q[$];
  logic [31:0] seed = 32'h0001_6213;
  int n_fail = 0;
  int checks_done = 0;
  event got;
  dpram_port_ctrl uut (.clk_sys, .sys_rst, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .mem_addr, .port_select_n,
    .semaphore_select_n, .rw_n, .oe_n, .byte_lane_selects_n, .bus_match_select, .bus_size_select,
    .dq_out, .dq_oe(), .dq_in, .busy_n, .mailbox_irq_n);
  dpram_dev_model dev (.mem_addr, .port_select_n, .semaphore_select_n, .rw_n, .oe_n,
    .byte_lane_selects_n, .bus_match_select, .bus_size_select, .dq_out, .dq_in, .busy_n,
    .mailbox_irq_n);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk32(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      n_fail++;
      $display("unexpected at %0t got %h expected %h", $time, g, x);
    end
  endtask : chk32
  // e holds {mask, value}; a zero mask marks an unchecked poll
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [63:0] e);
    logic rdy;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do begin
      @(negedge clk_sys);
      rdy = hreadyout;
      @(posedge clk_sys);
    end while (rdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(negedge clk_sys);
      rdy = hreadyout;
      got_d = hrdata;
      @(posedge clk_sys);
    end while (rdy !== 1'b1);
    if (!w) begin
      exp_q.push_back(e);
      ->got;
    end
  endtask : xfer
  task automatic op(input logic [3:0] c, input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, REG_ADDR, a, 64'h0);
    xfer(1'b1, REG_WDATA, d, 64'h0);
    xfer(1'b1, REG_CMD, {28'h000_0000, c}, 64'h0);
    for (int i = 0; i < 40; i++) begin
      xfer(1'b0, REG_STATUS, 32'h0, 64'h0);
      if (got_d[0] === 1'b1 && i > 1) break;
    end
  endtask : op
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial forever begin
    logic [63:0] e;
    @(got);
    e = exp_q.pop_front();
    if (e[63:32] !== 32'h0) chk32(got_d & e[63:32], e[31:0]);
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_fail++;
    wrap_up();
  end
  initial begin
    sys_rst = 1'b1;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    r = xs() & 32'h0000_7ff8;
    op(4'h7, r | 32'h3, xs() & 32'hffff_fffe);
    xfer(1'b0, REG_RDATA, 32'h0, {32'h1, 32'h0});
    dev.sem_wr(5, 2, 1'b0);
    op(4'h7, (xs() & 32'h0000_7ff8) | 32'h5, 32'h0);
    xfer(1'b0, REG_RDATA, 32'h0, {32'h1, 32'h1});
    dev.sem_wr(5, 2, 1'b1);
    op(4'h5, 32'h5, 32'h0);
    xfer(1'b0, REG_RDATA, 32'h0, {32'h1, 32'h0});
    op(4'hf, 32'h3, 32'h1);
    xfer(1'b0, REG_RDATA, 32'h0, {32'h1, 32'h1});
    $display("test token latches done");
    r = xs();
    dev.busy_drv <= 1'b0;
    fork
      op(4'h3, 32'h0000_0100, r);
      begin
        repeat (12) @(posedge clk_sys);
        dev.busy_drv <= 1'b1;
      end
    join
    xfer(1'b0, REG_STATUS, 32'h0, {32'h3, 32'h3});
    op(4'h1, 32'h0000_0100, 32'h0);
    xfer(1'b0, REG_RDATA, 32'h0, {32'hffff_ffff, r});
    $display("test busy hold done");
    r = xs();
    op(4'h3, 32'h7fff, r);
    chk32({31'h0, dev.peer_irq}, 32'h1);
    op(4'h1, 32'h7fff, 32'h0);
    xfer(1'b0, REG_RDATA, 32'h0, {32'hffff_ffff, r});
    dev.post({4'h0, ~r});
    repeat (4) @(posedge clk_sys);
    xfer(1'b0, REG_STATUS, 32'h0, {32'h8, 32'h8});
    op(4'h1, 32'h7fff, 32'h0);
    xfer(1'b0, REG_STATUS, 32'h0, {32'h8, 32'h8});
    op(4'h1, 32'h7ffe, 32'h0);
    xfer(1'b0, REG_RDATA, 32'h0, {32'hffff_ffff, ~r});
    xfer(1'b0, REG_RDATA_HI, 32'h0, {32'hf, 32'h0});
    repeat (4) @(posedge clk_sys);
    xfer(1'b0, REG_STATUS, 32'h0, {32'h8, 32'h0});
    xfer(1'b0, 32'h0000_0020, 32'h0, {32'hffff_ffff, 32'h0});
    $display("test mailbox done");
    wrap_up();
  end
endmodule : tb_dual_port_arbiter_mailbox_semaphore
